// >>> mps_pkg.sv
// constants and carriers of the mains parallel sequencer
// assumes one 50 MHz clock; times are counted in 1 ms ticks
package mps_pkg;

  localparam int unsigned CLK_HZ          = 50_000_000;
  localparam int unsigned TICK_US         = 1000;
  localparam int unsigned TICK_CYCLES     = (CLK_HZ / 1_000_000) * TICK_US;
  localparam int unsigned TICK_CNT_W      = 16;

  // 2 s breaker limit when the feedback input has no delay of its own
  localparam logic [31:0] BRK_DEF_LIMIT_MS = 32'h0000_07d0;
  // interface breaker must be open 0.5 s after the protection trip
  localparam logic [31:0] IFACE_LIMIT_MS  = 32'h0000_01f4;
  localparam logic [31:0] MS_PER_S        = 32'h0000_03e8;
  localparam logic [1:0]  LAST_ATTEMPT    = 2'h2;
  localparam logic [15:0] SYNC_UNLIMITED  = 16'hffff;
  localparam logic [15:0] SP_RESET        = 16'h0000;

  localparam logic [1:0]  IFACE_GEN       = 2'h1;
  localparam logic [1:0]  IFACE_MAINS     = 2'h2;
  localparam logic [1:0]  PMODE_FIXED     = 2'h1;
  localparam logic [1:0]  PMODE_EXCHANGE  = 2'h2;

  typedef enum logic [1:0] {OPM_OFF, OPM_AUTO, OPM_TEST, OPM_REMOTE} op_mode_t;

  typedef enum logic [3:0] {
    ST_IDLE, ST_START, ST_READY, ST_SYNC, ST_PARALLEL, ST_UNLOAD,
    ST_GEN_OPEN, ST_DUAL_OPEN, ST_BOTH_OPEN, ST_MAINS_CLOSE, ST_STOP
  } seq_state_t;

  typedef struct packed {
    logic               keep_supplying;
    logic               open_mains_on_fail;
    logic               test_load;
    logic               shutdown_variant;
    logic [1:0]         iface_sel;
    logic [1:0]         power_mode;
    logic               use_analog;
    logic [15:0]        fixed_power_mode_kw;
    logic signed [15:0] exchange_kw;
    logic [15:0]        ramp_kw_per_ms;
    logic [15:0]        discharge_kw_per_ms;
    logic [15:0]        unload_thr_kw;
    logic [15:0]        unload_time_s;
    logic [15:0]        sync_time_s;
    logic [15:0]        gen_fb_delay_ms;
    logic [15:0]        mains_fb_delay_ms;
  } cfg_t;

  typedef struct packed {
    logic gen_closed;
    logic mains_closed;
    logic gen_in_tol;
    logic engine_running;
    logic prot_trip;
    logic mains_ok;
  } fb_t;

  typedef struct packed {
    logic shutdown;
    logic deactivation;
    logic discharge;
    logic stop_req;
    logic start_inhibit;
    logic load_inhibit;
  } cause_t;

  typedef struct packed {
    logic failed_parallel_shutdown;
    logic interface_not_open_shutdown;
    logic gen_breaker_not_open_shutdown;
    logic gen_breaker_not_open_warning;
    logic mains_breaker_not_closed_warning;
  } alarm_t;

  localparam alarm_t ALARM_RESET = '0;

endpackage : mps_pkg

// >>> sync_bits.sv
// two-stage synchroniser for independent levels
// assumes slow levels; bits are not kept coherent
`timescale 1ns/1ns
module sync_bits #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         nrst,
  // levels
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  genvar i;
    for (i = 0; i < W; i++) begin : g_bit
      logic meta_q;
      logic stab_q;
      always_ff @(posedge clk) begin
        if (!nrst) begin
          meta_q <= 1'b0;
          stab_q <= 1'b0;
        end else begin
          meta_q <= din[i];
          stab_q <= meta_q;
        end
      end
      assign dout[i] = stab_q;
    end

endmodule : sync_bits

// >>> power_setpoint.sv
// generator power setpoint: fixed or exchange, ramp down on unload
// assumes tick is a one-cycle 1 ms enable and powers are in kW
`timescale 1ns/1ns
module power_setpoint (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               nrst,
  input  wire logic               tick,
  // sequencer phase
  input  wire logic               parallel,
  input  wire logic               unload,
  input  wire logic               unload_start,
  input  wire logic               discharge,
  input  wire mps_pkg::cfg_t      cfg,
  // measurements
  input  wire logic [15:0]        gen_kw,
  input  wire logic signed [15:0] mains_kw,
  input  wire logic [15:0]        analog_kw,
  // result
  output logic      [15:0]        sp_q
);

  logic        [15:0] sp_d;
  logic signed [17:0] want;
  logic        [15:0] rate;

  always_comb begin
    want = $signed({2'b00, gen_kw}) + {{2{mains_kw[15]}}, mains_kw}
         - {{2{cfg.exchange_kw[15]}}, cfg.exchange_kw};
    rate = discharge ? cfg.discharge_kw_per_ms : cfg.ramp_kw_per_ms;  // see [R13]
    sp_d = mps_pkg::SP_RESET;
    if (unload_start) begin
      sp_d = gen_kw;
    end else if (unload) begin
      sp_d = sp_q;
      if (tick) begin
        sp_d = (sp_q > rate) ? sp_q - rate : mps_pkg::SP_RESET;  // see [R13]
      end
    end else if (parallel) begin
      if (cfg.power_mode == mps_pkg::PMODE_EXCHANGE) begin
        // clamped into the generator's range
        if (want < 0) begin
          sp_d = mps_pkg::SP_RESET;  // see [R10]
        end else if (want > 18'sh0ffff) begin
          sp_d = 16'hffff;
        end else begin
          sp_d = want[15:0];  // see [R10]
        end
      end else if (cfg.power_mode == mps_pkg::PMODE_FIXED) begin
        sp_d = cfg.use_analog ? analog_kw : cfg.fixed_power_mode_kw;  // see [R10]
      end else begin
        sp_d = sp_q;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      sp_q <= mps_pkg::SP_RESET;
    end else begin
      sp_q <= sp_d;
    end
  end

endmodule : power_setpoint

// >>> mains_parallel_sequencer.sv
// automatic sequencer for one generator in continuous parallel with the mains
// assumes synchroniser, engine and protections outside; feedback 1 = closed
//
// Overview of operation
// [R1] auto: request only uninhibited and mains permits
// [R2] test and remote start always request
// [R3] keep-supplying: not-open warning requests until acknowledged
// [R4] open mains if generator breaker sticks; code does so only with open_mains_on_fail and a serious cause or discharge
// [R5] generator breaker closed unless any blocking cause
// [R6] mains closed except tripped interface with generator closed
// [R7] idle request starts engine, ready when in tolerance
// [R8] ready: stop, wait on inhibit, else synchronise
// [R9] synchronise within limit, else failed-parallel shutdown
// [R10] setpoint from fixed power or mains exchange
// [R11] parallel trip opens generator or both breakers
// [R12] serious causes open, others unload first
// [R13] ramp power to zero, then open generator
// [R14] unload aborted by shutdown or protection trip
// [R15] generator opening: three tries, interface 0.5 s
// [R16] normal opening failure: warning, then stop or parallel
// [R17] dual opening on mains-interface trip, stuck interface or reclose failure, 0.5 s
// [R18] dual opening waits for generator breaker to open
// [R19] both open always leads to mains re-closing
// [R20] mains closing: three tries, warning on failure
// [R21] feedback delay is breaker limit, else 2 s
// [R22] explicit state machine, counters, synchronised feedback
`timescale 1ns/1ns
module mains_parallel_sequencer #(
  parameter int unsigned TICK_CYCLES = mps_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic               CLK,
  input  wire logic               NRST,
  // mode and configuration
  input  wire mps_pkg::op_mode_t  OP_MODE,
  input  wire mps_pkg::cfg_t      CFG,
  // breaker feedback, engine and protection levels
  input  wire mps_pkg::fb_t       FB,
  input  wire mps_pkg::cause_t    CAUSES,
  // alarm acknowledge
  input  wire logic               WARN_ACK,
  input  wire logic               SHUTDOWN_RESET,
  // measurements
  input  wire logic [15:0]        GEN_KW,
  input  wire logic signed [15:0] MAINS_KW,
  input  wire logic [15:0]        ANALOG_KW,
  // engine and breaker commands
  output logic                    ENGINE_RUN,
  output logic                    SYNC_EN,
  output logic                    GEN_BRK_OPEN,
  output logic                    MAINS_BRK_OPEN,
  output logic                    MAINS_BRK_CLOSE,
  output logic                    GEN_CLOSE_PERMIT,
  output logic                    MAINS_KEEP_CLOSED,
  // status
  output mps_pkg::seq_state_t     STATE,
  output mps_pkg::alarm_t         ALARMS,
  output logic [15:0]             POWER_SP
);

  mps_pkg::fb_t        fb;
  mps_pkg::cause_t     cs;
  mps_pkg::seq_state_t state_q, state_d;
  mps_pkg::alarm_t     alarm_q, alarm_d, alarm_set;
  logic [mps_pkg::TICK_CNT_W-1:0] tick_cnt_q, tick_cnt_d;
  logic                tick_q, tick_d;
  logic [31:0]         ms_q, ms_d;
  logic [31:0]         trip_ms_q, trip_ms_d;
  logic [1:0]          try_q, try_d;
  logic [4:0]          cmd_q, cmd_d;
  logic                force_q, force_d;
  logic                permit_q, permit_d;
  logic                keep_q, keep_d;
  logic                req, keep_req, own_sd, serious, stop_cause, permit_now;
  logic                restart, gen_late, mains_late, sync_late, unload_done;
  logic [31:0]         gen_lim, mains_lim;

  localparam int unsigned TICK_CNT_W = mps_pkg::TICK_CNT_W;

  sync_bits #(.W($bits(mps_pkg::fb_t) + $bits(mps_pkg::cause_t))) u_sync (
    .clk  (CLK),
    .nrst (NRST),
    .din  ({FB, CAUSES}),
    .dout ({fb, cs})  // see [R22]
  );

  power_setpoint u_sp (
    .clk          (CLK),
    .nrst         (NRST),
    .tick         (tick_q),
    .parallel     (state_q == mps_pkg::ST_PARALLEL),
    .unload       (state_q == mps_pkg::ST_UNLOAD),
    .unload_start ((state_q != mps_pkg::ST_UNLOAD) && (state_d == mps_pkg::ST_UNLOAD)),
    .discharge    (cs.discharge),
    .cfg          (CFG),
    .gen_kw       (GEN_KW),
    .mains_kw     (MAINS_KW),
    .analog_kw    (ANALOG_KW),
    .sp_q         (POWER_SP)
  );

  // ms enable and the protection-trip time base
  always_comb begin
    tick_d     = 1'b0;
    tick_cnt_d = tick_cnt_q + 1'b1;
    if (tick_cnt_q == TICK_CNT_W'(TICK_CYCLES - 1)) begin
      tick_cnt_d = '0;
      tick_d     = 1'b1;
    end
    trip_ms_d = '0;
    if (fb.prot_trip) begin
      trip_ms_d = (tick_q && trip_ms_q != 32'hffff_ffff) ? trip_ms_q + 32'h1 : trip_ms_q;
    end
  end

  // causes and decisions
  always_comb begin
    own_sd   = alarm_q.failed_parallel_shutdown | alarm_q.interface_not_open_shutdown
             | alarm_q.gen_breaker_not_open_shutdown;
    serious  = cs.shutdown | cs.deactivation | own_sd;
    keep_req = CFG.keep_supplying & alarm_q.gen_breaker_not_open_warning
             & ~(serious | cs.discharge);  // see [R3]
    unique case (OP_MODE)
      mps_pkg::OPM_AUTO:   req = ~cs.start_inhibit & fb.mains_ok;  // see [R1]
      mps_pkg::OPM_TEST:   req = 1'b1;  // see [R2]
      mps_pkg::OPM_REMOTE: req = 1'b1;  // see [R2]
      mps_pkg::OPM_OFF:    req = 1'b0;
    endcase
    req        = req | keep_req;
    stop_cause = serious | cs.discharge | ~req;
    permit_now = fb.engine_running & ~serious & ~cs.discharge & ~cs.stop_req
               & ~fb.prot_trip & fb.mains_ok & ~cs.load_inhibit
               & ~(OP_MODE == mps_pkg::OPM_TEST && !CFG.test_load);  // see [R5]
    gen_lim    = (CFG.gen_fb_delay_ms != 16'h0) ? 32'(CFG.gen_fb_delay_ms)
               : mps_pkg::BRK_DEF_LIMIT_MS;  // see [R21]
    mains_lim  = (CFG.mains_fb_delay_ms != 16'h0) ? 32'(CFG.mains_fb_delay_ms)
               : mps_pkg::BRK_DEF_LIMIT_MS;  // see [R21]
    gen_late   = ms_q >= gen_lim;
    mains_late = ms_q >= mains_lim;
    sync_late  = (CFG.sync_time_s != mps_pkg::SYNC_UNLIMITED)
               && (ms_q >= 32'(CFG.sync_time_s) * mps_pkg::MS_PER_S);  // see [R9]
    unload_done = (GEN_KW < CFG.unload_thr_kw)
               || (ms_q >= 32'(CFG.unload_time_s) * mps_pkg::MS_PER_S);  // see [R13]
  end

  // sequence
  always_comb begin
    state_d   = state_q;
    try_d     = try_q;
    force_d   = force_q;
    restart   = 1'b0;
    alarm_set = mps_pkg::ALARM_RESET;
    unique case (state_q)
      mps_pkg::ST_IDLE: begin
        force_d = 1'b0;
        if (req && !serious) begin
          state_d = mps_pkg::ST_START;  // see [R7]
        end
      end
      mps_pkg::ST_START: begin
        if (stop_cause) begin
          state_d = mps_pkg::ST_STOP;
        end else if (fb.gen_in_tol) begin
          state_d = mps_pkg::ST_READY;  // see [R7]
        end
      end
      mps_pkg::ST_READY: begin
        if (stop_cause) begin
          state_d = mps_pkg::ST_STOP;  // see [R8]
        end else if (permit_now) begin
          state_d = mps_pkg::ST_SYNC;  // see [R8]
        end
      end
      mps_pkg::ST_SYNC: begin
        if (fb.gen_closed) begin
          state_d = mps_pkg::ST_PARALLEL;  // see [R9]
        end else if (sync_late) begin
          alarm_set.failed_parallel_shutdown = 1'b1;  // see [R9]
          state_d = mps_pkg::ST_STOP;
        end else if (serious) begin
          state_d = mps_pkg::ST_STOP;
        end
      end
      mps_pkg::ST_PARALLEL, mps_pkg::ST_UNLOAD: begin
        if (fb.prot_trip) begin
          state_d = (CFG.iface_sel == mps_pkg::IFACE_MAINS) ? mps_pkg::ST_DUAL_OPEN
                  : mps_pkg::ST_GEN_OPEN;  // see [R11] [R14]
        end else if (serious) begin
          state_d = mps_pkg::ST_GEN_OPEN;  // see [R12] [R14]
        end else if (state_q == mps_pkg::ST_PARALLEL) begin
          if (cs.discharge || !req || cs.load_inhibit) begin
            state_d = mps_pkg::ST_UNLOAD;  // see [R12]
          end
        end else if (unload_done) begin
          state_d = mps_pkg::ST_GEN_OPEN;  // see [R13]
        end
        try_d = '0;
      end
      mps_pkg::ST_GEN_OPEN: begin
        if (!fb.gen_closed) begin
          state_d = mps_pkg::ST_READY;  // see [R15]
        end else if (fb.prot_trip && CFG.iface_sel == mps_pkg::IFACE_GEN
                     && trip_ms_q >= mps_pkg::IFACE_LIMIT_MS) begin
          alarm_set.interface_not_open_shutdown = 1'b1;  // see [R15]
          state_d = mps_pkg::ST_DUAL_OPEN;
          try_d   = '0;
        end else if (gen_late && try_q != mps_pkg::LAST_ATTEMPT) begin
          try_d   = try_q + 2'h1;  // see [R15]
          restart = 1'b1;
        end else if (gen_late && !fb.prot_trip) begin
          // a stuck generator breaker with a grid still closed would drag it
          force_d = CFG.open_mains_on_fail & (serious | cs.discharge);  // see [R4]
          if (CFG.shutdown_variant) begin
            alarm_set.gen_breaker_not_open_shutdown = 1'b1;  // see [R16]
            state_d = mps_pkg::ST_STOP;
          end else begin
            alarm_set.gen_breaker_not_open_warning = 1'b1;  // see [R16]
            state_d = stop_cause ? mps_pkg::ST_STOP : mps_pkg::ST_PARALLEL;
          end
        end
      end
      mps_pkg::ST_DUAL_OPEN: begin
        if (fb.prot_trip && fb.mains_closed && trip_ms_q >= mps_pkg::IFACE_LIMIT_MS) begin
          alarm_set.interface_not_open_shutdown = 1'b1;  // see [R17]
        end
        if (!fb.gen_closed) begin
          state_d = fb.mains_closed ? mps_pkg::ST_READY : mps_pkg::ST_BOTH_OPEN;  // see [R18]
          try_d   = '0;
        end else if (gen_late && try_q != mps_pkg::LAST_ATTEMPT) begin
          try_d   = try_q + 2'h1;  // see [R17]
          restart = 1'b1;
        end else if (gen_late) begin
          alarm_set.gen_breaker_not_open_shutdown = 1'b1;  // see [R18]
        end
      end
      mps_pkg::ST_BOTH_OPEN: begin
        state_d = mps_pkg::ST_MAINS_CLOSE;  // see [R19]
        try_d   = '0;
      end
      mps_pkg::ST_MAINS_CLOSE: begin
        force_d = 1'b0;
        if (fb.mains_closed) begin
          state_d = mps_pkg::ST_READY;  // see [R20]
        end else if (mains_late && try_q != mps_pkg::LAST_ATTEMPT) begin
          try_d   = try_q + 2'h1;  // see [R20]
          restart = 1'b1;
        end else if (mains_late) begin
          alarm_set.mains_breaker_not_closed_warning = 1'b1;  // see [R20]
          try_d   = '0;
          state_d = (req && !serious && !cs.discharge) ? mps_pkg::ST_DUAL_OPEN
                  : mps_pkg::ST_STOP;  // see [R20]
        end
      end
      mps_pkg::ST_STOP: begin
        if (!fb.engine_running) begin
          state_d = mps_pkg::ST_IDLE;
        end
      end
      default: state_d = mps_pkg::ST_IDLE;
    endcase
    // per-state ms counter, cleared on every change and retry
    if (restart || state_d != state_q) begin
      ms_d = '0;  // see [R22]
    end else begin
      ms_d = (tick_q && ms_q != 32'hffff_ffff) ? ms_q + 32'h1 : ms_q;
    end
    // commands from the next state so they leave flops; low one cycle per retry
    cmd_d   = {(state_d != mps_pkg::ST_IDLE) && (state_d != mps_pkg::ST_STOP),
               state_d == mps_pkg::ST_SYNC,
               (state_d inside {mps_pkg::ST_GEN_OPEN, mps_pkg::ST_DUAL_OPEN}) && !restart,
               ((state_d == mps_pkg::ST_DUAL_OPEN) && !restart) || force_d,
               (state_d == mps_pkg::ST_MAINS_CLOSE) && !restart};
    // set wins over acknowledge
    alarm_d = alarm_q;
    if (WARN_ACK) begin
      alarm_d.gen_breaker_not_open_warning     = 1'b0;
      alarm_d.mains_breaker_not_closed_warning = 1'b0;
    end
    if (SHUTDOWN_RESET) begin
      alarm_d.failed_parallel_shutdown      = 1'b0;
      alarm_d.interface_not_open_shutdown   = 1'b0;
      alarm_d.gen_breaker_not_open_shutdown = 1'b0;
    end
    alarm_d  = alarm_d | alarm_set;
    permit_d = permit_now;
    keep_d   = ~(CFG.iface_sel == mps_pkg::IFACE_MAINS && fb.gen_closed
               && fb.prot_trip);  // see [R6]
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b0;
      trip_ms_q  <= '0;
      state_q    <= mps_pkg::ST_IDLE;
      ms_q       <= '0;
      try_q      <= '0;
      cmd_q      <= '0;
      force_q    <= 1'b0;
      alarm_q    <= mps_pkg::ALARM_RESET;
      permit_q   <= 1'b0;
      keep_q     <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_d;
      tick_q     <= tick_d;
      trip_ms_q  <= trip_ms_d;
      state_q    <= state_d;
      ms_q       <= ms_d;
      try_q      <= try_d;
      cmd_q      <= cmd_d;
      force_q    <= force_d;
      alarm_q    <= alarm_d;
      permit_q   <= permit_d;
      keep_q     <= keep_d;
    end
  end

  assign ENGINE_RUN        = cmd_q[4];
  assign SYNC_EN           = cmd_q[3];
  assign GEN_BRK_OPEN      = cmd_q[2];
  assign MAINS_BRK_OPEN    = cmd_q[1];
  assign MAINS_BRK_CLOSE   = cmd_q[0];
  assign GEN_CLOSE_PERMIT  = permit_q;
  assign MAINS_KEEP_CLOSED = keep_q;
  assign STATE             = state_q;
  assign ALARMS            = alarm_q;

endmodule : mains_parallel_sequencer

// >>> mains_parallel_sequencer_checker.sv
// port assertions for the mains parallel sequencer
// assumes one clock and the synchronous active-low reset
`timescale 1ns/1ns
module mains_parallel_sequencer_checker (
  // clock and reset
  input wire logic                CLK,
  input wire logic                NRST,
  // mode and levels
  input wire mps_pkg::op_mode_t   OP_MODE,
  input wire mps_pkg::fb_t        FB,
  input wire mps_pkg::cause_t     CAUSES,
  // commands and status
  input wire logic                ENGINE_RUN,
  input wire logic                SYNC_EN,
  input wire logic                GEN_BRK_OPEN,
  input wire logic                GEN_CLOSE_PERMIT,
  input wire logic                MAINS_KEEP_CLOSED,
  input wire mps_pkg::seq_state_t STATE,
  input wire mps_pkg::alarm_t     ALARMS
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  // three samples cover the two synchroniser flops
  sequence s_test_idle;
    (STATE == mps_pkg::ST_IDLE && OP_MODE == mps_pkg::OPM_TEST && ALARMS == '0 &&
     !CAUSES.shutdown && !CAUSES.deactivation) [*3];
  endsequence
  sequence s_auto_inhibit;
    (STATE == mps_pkg::ST_IDLE && OP_MODE == mps_pkg::OPM_AUTO && CAUSES.start_inhibit &&
     !ALARMS.gen_breaker_not_open_warning) [*4];
  endsequence
  sequence s_gen_gap;
    STATE == mps_pkg::ST_GEN_OPEN && !GEN_BRK_OPEN;
  endsequence
  property p_run_decode;
    ENGINE_RUN == !(STATE inside {mps_pkg::ST_IDLE, mps_pkg::ST_STOP});
  endproperty
  property p_sync_en;
    SYNC_EN == (STATE == mps_pkg::ST_SYNC);
  endproperty
  property p_idle_exit;
    STATE == mps_pkg::ST_IDLE |=> STATE inside {mps_pkg::ST_IDLE, mps_pkg::ST_START};
  endproperty
  property p_test_start;
    s_test_idle |-> ##[1:3] STATE == mps_pkg::ST_START;
  endproperty
  property p_auto_inhibit;
    s_auto_inhibit |=> STATE == mps_pkg::ST_IDLE;
  endproperty
  property p_permit_block;
    CAUSES.shutdown [*4] |-> !GEN_CLOSE_PERMIT;
  endproperty
  property p_mains_keep;
    !FB.prot_trip [*4] |-> MAINS_KEEP_CLOSED;
  endproperty
  property p_both_open;
    STATE == mps_pkg::ST_BOTH_OPEN |-> ##[1:2] STATE == mps_pkg::ST_MAINS_CLOSE;
  endproperty
  property p_dual_exit;
    STATE == mps_pkg::ST_DUAL_OPEN |=>
      STATE inside {mps_pkg::ST_DUAL_OPEN, mps_pkg::ST_BOTH_OPEN, mps_pkg::ST_READY};
  endproperty
  property p_retry_gap;
    s_gen_gap |=> GEN_BRK_OPEN || STATE != mps_pkg::ST_GEN_OPEN;
  endproperty
  a_run_decode: assert property (p_run_decode) else $error("engine run decode wrong");
  a_sync_en: assert property (p_sync_en) else $error("sync enable decode wrong");
  a_idle_exit: assert property (p_idle_exit) else $error("bad exit from idle");
  a_test_start: assert property (p_test_start) else $error("test mode no start");
  a_auto_inhibit: assert property (p_auto_inhibit) else $error("inhibited start");
  a_permit_block: assert property (p_permit_block) else $error("permit on shutdown");
  a_mains_keep: assert property (p_mains_keep) else $error("mains keep dropped");
  a_both_open: assert property (p_both_open) else $error("no mains reclose");
  a_dual_exit: assert property (p_dual_exit) else $error("bad exit from dual open");
  a_retry_gap: assert property (p_retry_gap) else $error("retry gap too long");
endmodule : mains_parallel_sequencer_checker

bind mains_parallel_sequencer mains_parallel_sequencer_checker chk_i (
  .CLK(CLK), .NRST(NRST), .OP_MODE(OP_MODE), .FB(FB), .CAUSES(CAUSES),
  .ENGINE_RUN(ENGINE_RUN), .SYNC_EN(SYNC_EN), .GEN_BRK_OPEN(GEN_BRK_OPEN),
  .GEN_CLOSE_PERMIT(GEN_CLOSE_PERMIT), .MAINS_KEEP_CLOSED(MAINS_KEEP_CLOSED),
  .STATE(STATE), .ALARMS(ALARMS));

// >>> breaker_model.sv
// breakers and engine, each moving DLY+1 cycles after a steady command
// assumes level commands; faults only when the bench asks
`timescale 1ns/1ns
module breaker_model #(
  parameter int DLY = 8
) (
  // clock
  input  wire logic clk,
  // commands
  input  wire logic sync_en,
  input  wire logic gen_open,
  input  wire logic mains_open,
  input  wire logic mains_close,
  input  wire logic run,
  // commanded faults
  input  wire logic gen_stuck,
  input  wire logic sync_fail,
  // feedback
  output logic      gen_closed,
  output logic      mains_closed,
  output logic      running
);
  int cg, cm, ce;
  initial begin
    gen_closed = 1'b0;
    mains_closed = 1'b1;
    running = 1'b0;
  end
  // a retry gap restarts the travel, as a real coil drop would
  always @(posedge clk) begin
    cg <= ((sync_en && !sync_fail && !gen_closed) || (gen_open && !gen_stuck && gen_closed)) ?
          cg + 1 : 0;
    cm <= ((mains_open && mains_closed) || (mains_close && !mains_closed)) ? cm + 1 : 0;
    ce <= (run != running) ? ce + 1 : 0;
    if (cg == DLY) gen_closed <= !gen_closed;
    if (cm == DLY) mains_closed <= !mains_closed;
    if (ce == DLY) running <= !running;
  end
endmodule : breaker_model

// >>> mains_parallel_sequencer_tb_top.sv
// self-checking bench: sequence, trips, timeouts, breaker faults
// assumes a 10-clock ms tick and 20 ms feedback limits
`timescale 1ns/1ns
module mains_parallel_sequencer_tb_top;
  logic                CLK, NRST, WARN_ACK, SHUTDOWN_RESET, prot_trip, mains_ok;
  logic                gen_closed, mains_closed, running, gen_stuck, sync_fail;
  logic                ENGINE_RUN, SYNC_EN, GEN_BRK_OPEN, MAINS_BRK_OPEN, MAINS_BRK_CLOSE;
  logic                GEN_CLOSE_PERMIT, MAINS_KEEP_CLOSED;
  logic [15:0]         GEN_KW, ANALOG_KW, POWER_SP;
  logic signed [15:0]  MAINS_KW;
  mps_pkg::op_mode_t   op_mode;
  mps_pkg::cfg_t       cfg;
  mps_pkg::cause_t     cs;
  mps_pkg::fb_t        fb;
  mps_pkg::seq_state_t STATE;
  mps_pkg::alarm_t     ALARMS;
  int                  err_total, checks;
  assign fb = mps_pkg::fb_t'({gen_closed, mains_closed, running, running, prot_trip, mains_ok});
  mains_parallel_sequencer #(.TICK_CYCLES(10)) DUT (
    .CLK(CLK), .NRST(NRST), .OP_MODE(op_mode), .CFG(cfg), .FB(fb), .CAUSES(cs),
    .WARN_ACK(WARN_ACK), .SHUTDOWN_RESET(SHUTDOWN_RESET), .GEN_KW(GEN_KW),
    .MAINS_KW(MAINS_KW), .ANALOG_KW(ANALOG_KW), .ENGINE_RUN(ENGINE_RUN), .SYNC_EN(SYNC_EN),
    .GEN_BRK_OPEN(GEN_BRK_OPEN), .MAINS_BRK_OPEN(MAINS_BRK_OPEN),
    .MAINS_BRK_CLOSE(MAINS_BRK_CLOSE), .GEN_CLOSE_PERMIT(GEN_CLOSE_PERMIT),
    .MAINS_KEEP_CLOSED(MAINS_KEEP_CLOSED), .STATE(STATE), .ALARMS(ALARMS), .POWER_SP(POWER_SP));
  breaker_model #(.DLY(8)) far_i (
    .clk(CLK), .sync_en(SYNC_EN), .gen_open(GEN_BRK_OPEN), .mains_open(MAINS_BRK_OPEN),
    .mains_close(MAINS_BRK_CLOSE), .run(ENGINE_RUN), .gen_stuck(gen_stuck),
    .sync_fail(sync_fail), .gen_closed(gen_closed), .mains_closed(mains_closed),
    .running(running));
  initial begin
    CLK = 1'b0;
    forever #10 CLK = !CLK;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge CLK);
  endtask : cyc
  task automatic wst(input mps_pkg::seq_state_t s, input int lim);
    int n;
    n = 0;
    while (STATE !== s && n < lim) begin
      @(negedge CLK);
      n++;
    end
    chk("state", 32'(STATE), 32'(s));
  endtask : wst
  task automatic complete_run();
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : complete_run
  initial begin
    #800_000;
    err_total++;
    complete_run();
  end
  initial begin
    err_total = 0;
    checks = 0;
    NRST = 1'b0;
    {WARN_ACK, SHUTDOWN_RESET, prot_trip, gen_stuck, sync_fail} = '0;
    mains_ok = 1'b1;
    op_mode = mps_pkg::OPM_OFF;
    cs = '0;
    cfg = '0;
    cfg.iface_sel = mps_pkg::IFACE_MAINS;
    cfg.power_mode = mps_pkg::PMODE_FIXED;
    cfg.fixed_power_mode_kw = 16'h00c8;
    cfg.exchange_kw = 16'sh001e;
    {cfg.ramp_kw_per_ms, cfg.discharge_kw_per_ms} = {16'h0010, 16'h0020};
    {cfg.unload_thr_kw, cfg.unload_time_s, cfg.sync_time_s} = {16'h0014, 16'h0001, 16'h0001};
    {cfg.gen_fb_delay_ms, cfg.mains_fb_delay_ms} = {16'h0014, 16'h0014};
    {cfg.test_load, cfg.open_mains_on_fail} = 2'h3;
    {GEN_KW, MAINS_KW, ANALOG_KW} = {16'h000a, 16'sh0032, 16'h0000};
    cyc(8);
    NRST = 1'b1;
    wst(mps_pkg::ST_IDLE, 0);
    chk("keep", 32'(MAINS_KEEP_CLOSED), 32'h1);
    chk("alarms", 32'(ALARMS), 32'h0);
    op_mode = mps_pkg::OPM_AUTO;
    cs.start_inhibit = 1'b1;
    cyc(20);
    wst(mps_pkg::ST_IDLE, 0);
    cs.start_inhibit = 1'b0;
    wst(mps_pkg::ST_START, 10);
    chk("run", 32'(ENGINE_RUN), 32'h1);
    wst(mps_pkg::ST_READY, 50);
    wst(mps_pkg::ST_SYNC, 50);
    wst(mps_pkg::ST_PARALLEL, 50);
    cyc(5);
    chk("setpoint", 32'(POWER_SP), 32'h00c8);
    cfg.power_mode = mps_pkg::PMODE_EXCHANGE;
    cyc(5);
    chk("setpoint", 32'(POWER_SP), 32'h001e);
    cs.load_inhibit = 1'b1;
    wst(mps_pkg::ST_UNLOAD, 10);
    wst(mps_pkg::ST_GEN_OPEN, 300);
    wst(mps_pkg::ST_READY, 300);
    cyc(20);
    wst(mps_pkg::ST_READY, 0);
    chk("permit", 32'(GEN_CLOSE_PERMIT), 32'h0);
    cs.load_inhibit = 1'b0;
    wst(mps_pkg::ST_PARALLEL, 200);
    prot_trip = 1'b1;
    wst(mps_pkg::ST_DUAL_OPEN, 10);
    cyc(1);
    chk("keep", 32'(MAINS_KEEP_CLOSED), 32'h0);
    wst(mps_pkg::ST_BOTH_OPEN, 100);
    prot_trip = 1'b0;
    wst(mps_pkg::ST_MAINS_CLOSE, 5);
    chk("mains close", 32'(MAINS_BRK_CLOSE), 32'h1);
    wst(mps_pkg::ST_READY, 300);
    chk("alarms", 32'(ALARMS), 32'h0);
    wst(mps_pkg::ST_PARALLEL, 200);
    cfg.iface_sel = mps_pkg::IFACE_GEN;
    prot_trip = 1'b1;
    wst(mps_pkg::ST_GEN_OPEN, 10);
    sync_fail = 1'b1;
    wst(mps_pkg::ST_READY, 300);
    prot_trip = 1'b0;
    wst(mps_pkg::ST_SYNC, 100);
    wst(mps_pkg::ST_STOP, 10100);
    chk("failed parallel", 32'(ALARMS.failed_parallel_shutdown), 32'h1);
    wst(mps_pkg::ST_IDLE, 100);
    {cs.start_inhibit, mains_ok} = 2'h2;
    cyc(3);
    SHUTDOWN_RESET = 1'b1;
    cyc(1);
    {SHUTDOWN_RESET, sync_fail} = 2'h0;
    cyc(3);
    chk("alarms", 32'(ALARMS), 32'h0);
    wst(mps_pkg::ST_IDLE, 0);
    op_mode = mps_pkg::OPM_TEST;
    wst(mps_pkg::ST_START, 10);
    {cs.start_inhibit, mains_ok} = 2'h1;
    wst(mps_pkg::ST_PARALLEL, 300);
    {gen_stuck, cs.shutdown} = 2'h3;
    wst(mps_pkg::ST_GEN_OPEN, 10);
    wst(mps_pkg::ST_STOP, 800);
    chk("gen warning", 32'(ALARMS.gen_breaker_not_open_warning), 32'h1);
    chk("mains open", 32'(MAINS_BRK_OPEN), 32'h1);
    complete_run();
  end
endmodule : mains_parallel_sequencer_tb_top
